// file: hw/bic_pkg.sv
// Package of constants and types for the bus idle-cycle insertion block
package bic_pkg;
    // ****************************************
    // Register map
    // ****************************************
    localparam int NUM_SPACES = 8;
    localparam logic [5:0] OFS_CTRL0 = 6'h00; // Space 0 control, spaces follow every 4 bytes
    localparam logic [5:0] OFS_STATUS = 6'h20;
    localparam logic [31:0] CTRL_RESET = 32'h36db0540;
    localparam logic [31:0] CTRL_WMASK = 32'h7fffffff; // Top bit reserved, reads zero
    // Space indices
    localparam logic [2:0] SP_0 = 3'h0;
    localparam logic [2:0] SP_2 = 3'h1;
    localparam logic [2:0] SP_3 = 3'h2;
    localparam logic [2:0] SP_4 = 3'h3;
    localparam logic [2:0] SP_5A = 3'h4;
    localparam logic [2:0] SP_5B = 3'h5;
    localparam logic [2:0] SP_6A = 3'h6;
    localparam logic [2:0] SP_6B = 3'h7;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int WFI_LSB = 28; // write_follow_idle 30:28
    localparam int RWO_LSB = 25; // read_write_other_space_idle 27:25
    localparam int RWS_LSB = 22; // read_write_same_space_idle 24:22
    localparam int ST_HOLD = 0;
    localparam int ST_BUSY = 1;
    localparam int ST_VALID = 2;
    localparam int ST_DIR = 3;
    localparam int ST_SPACE_LSB = 4;
    localparam int ST_CNT_LSB = 8;
    // Idle count used when the write-follow field holds the reserved value
    localparam logic [3:0] WFI_RESERVED_CNT = 4'h1;
    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        BIC_READY = 2'b00,
        BIC_CALC = 2'b01,
        BIC_HOLD = 2'b10,
        BIC_BUSY = 2'b11
    } bic_state_t;
endpackage

// file: hw/bic_regmem.sv
// Eight per-space control words with two registered read ports
`timescale 1ns/1ps
module bic_regmem
    import bic_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Write port
    input wire logic wr_en,
    input wire logic [2:0] wr_idx,
    input wire logic [31:0] wr_data,
    // Bus read port
    input wire logic [2:0] ra_idx,
    output logic [31:0] ra_q,
    // Idle lookup read port
    input wire logic [2:0] rb_idx,
    output logic [31:0] rb_q
);
    logic [31:0] mem_r [NUM_SPACES];
    logic [31:0] mem_nxt [NUM_SPACES];
    logic [31:0] ra_nxt;
    logic [31:0] rb_nxt;

    // Next contents and read data
    always_comb begin
        for (int i = 0; i < NUM_SPACES; i++) begin
            mem_nxt[i] = mem_r[i];
        end
        if (wr_en) begin
            mem_nxt[wr_idx] = wr_data & CTRL_WMASK;
        end
        ra_nxt = mem_r[ra_idx];
        rb_nxt = mem_r[rb_idx];
    end

    // Storage and output registers
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_SPACES; i++) begin
                mem_r[i] <= CTRL_RESET;
            end
            ra_q <= 32'h00000000;
            rb_q <= CTRL_RESET;
        end else begin
            for (int i = 0; i < NUM_SPACES; i++) begin
                mem_r[i] <= mem_nxt[i];
            end
            ra_q <= ra_nxt;
            rb_q <= rb_nxt;
        end
    end
endmodule

// file: hw/bic_idle.sv
// Idle-cycle insertion between external accesses, with per-space control registers
`timescale 1ns/1ps
module bic_idle
    import bic_pkg::*;
(
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Register port
    input wire logic [5:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Bus clock enable from the controller
    input wire logic bclk_en,
    // Access request from the controller
    input wire logic acc_req,
    input wire logic [2:0] acc_space,
    input wire logic acc_write,
    output logic acc_grant,
    input wire logic acc_end,
    // Bus state
    output logic bus_idle
);
    // ****************************************
    // Decode helpers
    // ****************************************
    // Idle cycle count of a three-bit field code
    function automatic logic [3:0] idle_decode(input logic [2:0] code);
        logic [3:0] n;
        n = 4'h0;
        case (code)
            3'h0: n = 4'h0;
            3'h1: n = 4'h1;
            3'h2: n = 4'h2;
            3'h3: n = 4'h4;
            3'h4: n = 4'h6;
            3'h5: n = 4'h8;
            3'h6: n = 4'ha;
            3'h7: n = 4'hc;
            default: n = 4'h0;
        endcase
        return n;
    endfunction

    // Register index of a control word address, valid flag in the top bit
    function automatic logic [3:0] ctrl_index(input logic [5:0] a);
        logic [3:0] r;
        r = {1'b0, a[4:2]};
        if (a[5] || a[1:0] != 2'h0) begin
            r = 4'h0;
        end else begin
            r[3] = 1'b1;
        end
        return r;
    endfunction

    // ****************************************
    // Register access
    // ****************************************
    logic [3:0] wr_dec;
    logic [3:0] rd_dec;
    logic [31:0] mem_q;
    logic [31:0] prev_q;
    logic [31:0] status_w;
    logic [31:0] stat_r;
    logic [31:0] stat_nxt;
    logic [1:0] rsel_r;
    logic [1:0] rsel_nxt;
    logic [2:0] look_idx;

    assign wr_dec = ctrl_index(reg_addr);
    assign rd_dec = ctrl_index(reg_addr);

    // One control word per space, read data registered inside
    bic_regmem u_mem (
        .mclk(mclk),
        .nrst(nrst),
        .wr_en(reg_wr && wr_dec[3]),
        .wr_idx(wr_dec[2:0]),
        .wr_data(reg_wdata),
        .ra_idx(rd_dec[2:0]),
        .ra_q(mem_q),
        .rb_idx(look_idx),
        .rb_q(prev_q)
    );

    // Read source select: 1 control, 2 status, 0 unmapped
    always_comb begin
        rsel_nxt = 2'h0;
        stat_nxt = stat_r;
        if (reg_rd) begin
            if (rd_dec[3]) begin
                rsel_nxt = 2'h1;
            end else if (reg_addr == OFS_STATUS) begin
                rsel_nxt = 2'h2;
                stat_nxt = status_w;
            end
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            rsel_r <= 2'h0;
            stat_r <= 32'h00000000;
        end else begin
            rsel_r <= rsel_nxt;
            stat_r <= stat_nxt;
        end
    end

    // Read data valid in the cycle after the strobe, unmapped reads zero
    always_comb begin
        case (rsel_r)
            2'h1: reg_rdata = mem_q;
            2'h2: reg_rdata = stat_r;
            default: reg_rdata = 32'h00000000;
        endcase
    end

    // ****************************************
    // Idle sequencer
    // ****************************************
    bic_state_t state_r;
    bic_state_t state_nxt;
    logic [3:0] cnt_r;
    logic [3:0] cnt_nxt;
    logic [2:0] prev_sp_r;
    logic [2:0] prev_sp_nxt;
    logic prev_wr_r;
    logic prev_wr_nxt;
    logic prev_vld_r;
    logic prev_vld_nxt;
    logic [3:0] need;
    logic [3:0] wfi_cnt;

    // Lookup always reads the previous access's space
    assign look_idx = prev_sp_r;

    // Write-followed count, reserved code treated as one cycle
    always_comb begin
        wfi_cnt = idle_decode(prev_q[WFI_LSB +: 3]);
        if (prev_q[WFI_LSB +: 3] == 3'h0) begin
            wfi_cnt = WFI_RESERVED_CNT;
        end
    end

    // Idle count for the pending access after the previous one
    always_comb begin
        need = 4'h0;
        if (prev_vld_r) begin
            if (prev_wr_r) begin
                need = wfi_cnt;
            end else if (acc_write && acc_space == prev_sp_r) begin
                need = idle_decode(prev_q[RWS_LSB +: 3]);
            end else if (acc_write) begin
                need = idle_decode(prev_q[RWO_LSB +: 3]);
            end
        end
    end

    // Next state of the sequencer
    always_comb begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        prev_sp_nxt = prev_sp_r;
        prev_wr_nxt = prev_wr_r;
        prev_vld_nxt = prev_vld_r;
        acc_grant = 1'b0;
        case (state_r)
            BIC_READY: begin
                // Wait one cycle so the lookup reflects any fresh write
                if (acc_req) begin
                    state_nxt = BIC_CALC;
                end
            end
            BIC_CALC: begin
                if (!acc_req) begin
                    state_nxt = BIC_READY;
                end else if (need == 4'h0) begin
                    acc_grant = 1'b1;
                    prev_sp_nxt = acc_space;
                    prev_wr_nxt = acc_write;
                    prev_vld_nxt = 1'b1;
                    state_nxt = BIC_BUSY;
                end else begin
                    cnt_nxt = need;
                    state_nxt = BIC_HOLD;
                end
            end
            BIC_HOLD: begin
                // Count bus clocks with the bus held idle
                if (bclk_en) begin
                    cnt_nxt = cnt_r - 4'h1;
                    if (cnt_r == 4'h1) begin
                        state_nxt = BIC_CALC;
                        prev_vld_nxt = 1'b0;
                    end
                end
            end
            BIC_BUSY: begin
                if (acc_end) begin
                    state_nxt = BIC_READY;
                end
            end
            default: begin
                state_nxt = BIC_READY;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r <= BIC_READY;
            cnt_r <= 4'h0;
            prev_sp_r <= SP_0;
            prev_wr_r <= 1'b0;
            prev_vld_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            prev_sp_r <= prev_sp_nxt;
            prev_wr_r <= prev_wr_nxt;
            prev_vld_r <= prev_vld_nxt;
        end
    end

    assign bus_idle = (state_r == BIC_HOLD);

    // Status word for software
    always_comb begin
        status_w = 32'h00000000;
        status_w[ST_HOLD] = (state_r == BIC_HOLD);
        status_w[ST_BUSY] = (state_r == BIC_BUSY);
        status_w[ST_VALID] = prev_vld_r;
        status_w[ST_DIR] = prev_wr_r;
        status_w[ST_SPACE_LSB +: 3] = prev_sp_r;
        status_w[ST_CNT_LSB +: 4] = cnt_r;
    end
endmodule

// file: tb/bic_mem_model.sv
// Memory-side model that ends each granted access after a set latency
`timescale 1ns/1ps
module bic_mem_model (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Access handshake
    input wire logic acc_grant,
    input wire logic [3:0] lat,
    output logic acc_end
);
    logic busy_r;
    logic [3:0] cnt_r;
    // Wait out the latency after a grant, then pulse the end
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            busy_r <= 1'b0;
            cnt_r <= 4'h0;
            acc_end <= 1'b0;
        end else begin
            acc_end <= busy_r && cnt_r == 4'h0;
            busy_r <= acc_grant || (busy_r && cnt_r != 4'h0);
            cnt_r <= acc_grant ? lat : cnt_r - 4'(busy_r);
        end
    end
endmodule

// file: tb/bic_idle_assertions.sv
// Port checks of the idle-cycle insertion block
`timescale 1ns/1ps
module bic_idle_assertions (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Register port
    input wire logic [5:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [31:0] reg_rdata,
    // Access handshake
    input wire logic bclk_en,
    input wire logic acc_req,
    input wire logic acc_grant,
    input wire logic bus_idle
);
    logic [4:0] held_r;
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    // Bus clocks seen while idle is held
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            held_r <= 5'h00;
        end else begin
            held_r <= bus_idle ? held_r + 5'(bclk_en) : 5'h00;
        end
    end
    top_bit_a: assert property (reg_rdata[31] == 1'b0) else $error("top bit set");
    rdata_quiet_a: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray data");
    grant_pulse_a: assert property (acc_grant |=> !acc_grant) else $error("long grant");
    grant_req_a: assert property (acc_grant |-> acc_req && !bus_idle) else $error("bad grant");
    hold_req_a: assert property (bus_idle |-> acc_req) else $error("idle without request");
    hold_end_a: assert property ($fell(bus_idle) |-> acc_grant) else $error("no grant after idle");
    hold_count_a: assert property ($fell(bus_idle) |-> held_r inside {1, 2, 4, 6, 8, 10, 12})
        else $error("bad idle count");
    hold_max_a: assert property (bus_idle |-> held_r <= 5'h0c) else $error("idle too long");
    hold_bound_a: assert property ($rose(bus_idle) |-> ##[1:1000] !bus_idle) else $error("stuck idle");
    unmapped_read_a: assert property (reg_rd && (reg_addr[1:0] != 2'h0 || reg_addr > 6'h20) |=> reg_rdata == 32'h0)
        else $error("unmapped read data");
    cover property ($fell(bus_idle));
    cover property (acc_grant && !$past(bus_idle));
    cover property (reg_rd ##1 reg_rdata != 32'h0);
endmodule
bind bic_idle bic_idle_assertions u_chk (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .bclk_en(bclk_en), .acc_req(acc_req), .acc_grant(acc_grant), .bus_idle(bus_idle));

// file: tb/tb_bus_idle_cycle_insertion.sv
// Self-checking bench of the idle-cycle insertion block
`timescale 1ns/1ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin errors++; $display("BAD t=%0t got %h exp %h", $time, g, e); end end
module tb_bus_idle_cycle_insertion
    import bic_pkg::*;
;
    logic mclk = 1'b0, nrst = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, bclk_en = 1'b0, acc_req = 1'b0, acc_write = 1'b0;
    logic [5:0] reg_addr = 6'h00;
    logic [31:0] reg_wdata = 32'h0, rd, reg_rdata;
    logic [2:0] acc_space = 3'h0;
    logic [3:0] lat = 4'h0;
    logic acc_grant, acc_end, bus_idle;
    int errors = 0, comparisons = 0, cyc = 0, n, e, c;
    // Rows: field code, idle after a write, idle after a read then a write
    int rows[8][3] = '{'{0, 1, 0}, '{1, 1, 1}, '{2, 2, 2}, '{3, 4, 4}, '{4, 6, 6}, '{5, 8, 8}, '{6, 10, 10},
        '{7, 12, 12}};
    bic_idle dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bclk_en(bclk_en), .acc_req(acc_req), .acc_space(acc_space),
        .acc_write(acc_write), .acc_grant(acc_grant), .acc_end(acc_end), .bus_idle(bus_idle));
    bic_mem_model mem (.mclk(mclk), .nrst(nrst), .acc_grant(acc_grant), .lat(lat), .acc_end(acc_end));
    // Clock, bus clock every second cycle, run ceiling
    always #2.5 mclk = ~mclk;
    always @(posedge mclk) begin
        bclk_en <= ~bclk_en;
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            errors++;
            conclude();
        end
    end
    task automatic conclude();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic wr(input logic [5:0] a, input logic [31:0] d);
        @(posedge mclk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge mclk);
        reg_wr <= 1'b0;
    endtask
    task automatic rdw(input logic [5:0] a);
        @(posedge mclk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(negedge mclk);
        rd = reg_rdata;
    endtask
    // One access; n counts bus clocks held idle before the grant
    task automatic acc(input logic [2:0] s, input logic w);
        @(posedge mclk);
        acc_req <= 1'b1;
        acc_space <= s;
        acc_write <= w;
        n = 0;
        repeat (200) begin
            @(negedge mclk);
            if (bus_idle === 1'b1 && bclk_en === 1'b1) n++;
            if (acc_grant === 1'b1) break;
        end
        @(posedge mclk);
        acc_req <= 1'b0;
        repeat (40) begin
            @(negedge mclk);
            if (acc_end === 1'b1) break;
        end
    endtask
    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        // Every control word written before any access beyond space 0
        for (int s = 0; s < 8; s++) begin
            wr(6'(s * 4), CTRL_RESET);
        end
        // One row per code, through write-follow, read-write other space and same space
        for (int r = 0; r < 8; r++) begin
            for (int t = 0; t < 3; t++) begin
                c = rows[r][0];
                wr(6'(c * 4), {1'b0, 3'(t == 0 ? c : 7 - c), 3'(t == 1 ? c : 7 - c), 3'(t == 2 ? c : 7 - c), 22'h0});
                lat <= 4'(c % 3);
                acc(3'(c), t == 0);
                acc(3'(t == 1 ? c + 1 : c), t != 0);
                e = rows[r][t == 0 ? 1 : 2];
                `CHK(n, e)
            end
        end
        // Read after read adds nothing
        acc(3'h0, 1'b0);
        acc(3'h1, 1'b0);
        `CHK(n, 0)
        // Reserved top bit, back-to-back write and read, unmapped place
        wr(6'h1c, 32'hffffffff);
        rdw(6'h1c);
        `CHK(rd, CTRL_WMASK)
        rdw(6'h24);
        `CHK(rd, 32'h0)
        // Mid-run reset restores every word
        @(posedge mclk);
        nrst <= 1'b0;
        repeat (8) @(posedge mclk);
        nrst <= 1'b1;
        for (int s = 0; s < 8; s++) begin
            rdw(6'(s * 4));
            `CHK(rd, CTRL_RESET)
        end
        acc(3'h2, 1'b1);
        acc(3'h2, 1'b0);
        `CHK(n, 4)
        // Status shows the last access: valid, a read, space index 2
        rdw(OFS_STATUS);
        `CHK(rd, 32'(1 << ST_VALID) | 32'(2 << ST_SPACE_LSB))
        conclude();
    end
endmodule
